// ### bbw_pkg.sv
// shared constants, carriers and decode helpers for the bus and i/o window config bank
package bbw_pkg;
  // configuration byte offsets
  localparam logic [7:0] BBW_OFS_UP_BUS = 8'h18;
  localparam logic [7:0] BBW_OFS_DOWN_BUS = 8'h19;
  localparam logic [7:0] BBW_OFS_HIGH_BUS = 8'h1A;
  localparam logic [7:0] BBW_OFS_LAT = 8'h1B;
  localparam logic [7:0] BBW_OFS_IO_LOW = 8'h1C;
  localparam logic [7:0] BBW_OFS_IO_HIGH = 8'h1D;
  localparam logic [7:0] BBW_OFS_ST_LO = 8'h1E;
  localparam logic [7:0] BBW_OFS_ST_HI = 8'h1F;
  // reset values
  localparam logic [7:0] BBW_BUS_RST = 8'h00;
  localparam logic [7:0] BBW_LAT_RST = 8'h00;
  localparam logic [3:0] BBW_IO_FIELD_RST = 4'h0;
  // i/o window layout
  localparam int BBW_IO_FIELD_POS = 4;
  localparam logic [3:0] BBW_IO_KIND = 4'h1;
  localparam logic [11:0] BBW_IO_LOW_PAD = 12'h000;
  localparam logic [11:0] BBW_IO_HIGH_PAD = 12'hFFF;
  // status layout
  localparam int BBW_ST_PAR = 15;
  localparam int BBW_ST_SYS = 14;
  localparam int BBW_ST_MABORT = 13;
  localparam int BBW_ST_TAB_REC = 12;
  localparam int BBW_ST_TAB_SIG = 11;
  localparam int BBW_ST_DPAR = 8;
  localparam int BBW_ST_FLAGS = 6;
  localparam logic [15:0] BBW_ST_FIXED = 16'h0280;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bbw_cfg_req_t;

  typedef struct packed {
    logic addr_attr_perr;
    logic tgt_wr_perr;
    logic mst_rd_perr;
    logic serr;
    logic mabort;
    logic tabort_rec;
    logic tabort_sig;
    logic mst_data_perr;
  } bbw_sec_evt_t;

  typedef enum logic [1:0] {BBW_CFG1_IGNORE, BBW_CFG1_TO_TYPE0, BBW_CFG1_PASS} bbw_cfg1_route_t;

  function automatic logic bbw_byte_wr(bbw_cfg_req_t r, logic [7:0] ofs);
    return r.wr && (r.addr[7:2] == ofs[7:2]) && r.be[ofs[1:0]];
  endfunction

  function automatic logic [7:0] bbw_byte_data(bbw_cfg_req_t r, logic [7:0] ofs);
    return r.wdata[{ofs[1:0], 3'b000} +: 8];
  endfunction

  function automatic logic bbw_dw_rd(bbw_cfg_req_t r, logic [7:0] ofs);
    return r.rd && (r.addr[7:2] == ofs[7:2]);
  endfunction
endpackage

// ### bbw_io_window.sv
// i/o window range compare
`timescale 1ns/1ps
module bbw_io_window
  import bbw_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic [3:0] io_window_low_field,
  input wire logic [3:0] io_window_high_field,
  input wire logic [15:0] base_upper,
  input wire logic [15:0] limit_upper,
  input wire logic [AW-1:0] addr,
  output logic hit
);
  logic [AW-1:0] bottom;
  logic [AW-1:0] top;

  assign bottom = AW'({base_upper, io_window_low_field, BBW_IO_LOW_PAD});
  assign top = AW'({limit_upper, io_window_high_field, BBW_IO_HIGH_PAD});
  assign hit = (addr >= bottom) && (addr <= top);
endmodule

// ### bbw_err_flags.sv
// sticky error flags, set by events and cleared by writing one
`timescale 1ns/1ps
module bbw_err_flags #(
  parameter int N = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);
  logic [N-1:0] flags_q;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (rst) begin
          flags_q[i] <= 1'b0;
        end else if (set[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clr[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flags_q;
endmodule

// ### bbw_bridge_bus_io_window_config.sv
// bus numbers, latency timer, i/o window and downstream status of a bridge header
// Operation
// - upstream bus number, 8-bit read/write at 18h, resets to 00h.
// - downstream bus number, 8-bit read/write at 19h, resets 00h, steers type 1.
// - type 1 answer uses both downstream and highest downstream bus numbers.
// - latency timer at 1Bh, read/write, resets 00h, counts bus clock cycles.
// - i/o window bottom register at 1Ch resets to 01h.
// - low nibble of both i/o window registers reads 1h, read only.
// - window top at 1Dh, bits 7:4 give address 15:12, low bits all ones.
// - address bits 31:16 of the top come from the upper-half register.
// - forward i/o only when the address lies inside the programmed window.
// - 16-bit status at 1Eh, resets with bits 9 and 7 set, others clear.
// - bit 15 sets on address or attribute error as potential target.
// - bit 15 sets on data error as write target or read master.
// - bit 15 parity flag sets regardless of the parity response enable; bit 8 sets only while it is on.
// - bit 14 sets on system error seen on the downstream bus.
`timescale 1ns/1ps
module bbw_bridge_bus_io_window_config
  import bbw_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire bbw_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_hit,
  input wire logic cfg1_valid,
  input wire logic [7:0] cfg1_bus,
  output bbw_cfg1_route_t cfg1_route,
  output logic cfg1_route_valid,
  input wire logic io_req_valid,
  input wire logic [AW-1:0] io_req_addr,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  output logic io_fwd_valid,
  output logic io_fwd_hit,
  input wire logic parity_response_enable,
  input wire bbw_sec_evt_t sec_evt,
  input wire logic sec_own_start,
  input wire logic sec_own_busy,
  input wire logic sec_gnt,
  output logic lat_release,
  output logic [7:0] upstream_bus_number,
  output logic [7:0] downstream_bus_number,
  output logic [7:0] highest_downstream_bus_number,
  output logic [7:0] downstream_latency_timer,
  output logic [15:0] downstream_bus_error_status
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] up_bus_q;
  logic [7:0] down_bus_q;
  logic [7:0] high_bus_q;
  logic [7:0] lat_q;
  logic [3:0] io_window_low_field_q;
  logic [3:0] io_window_high_field_q;
  logic [BBW_ST_FLAGS-1:0] flag_set;
  logic [BBW_ST_FLAGS-1:0] flag_clr;
  logic [BBW_ST_FLAGS-1:0] flags;
  logic [15:0] status;
  logic [7:0] io_low_byte;
  logic [7:0] io_high_byte;
  logic [15:0] st_clr16;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic hit_q;
  bbw_cfg1_route_t route_d;
  bbw_cfg1_route_t route_q;
  logic route_valid_q;
  logic win_hit;
  logic fwd_valid_q;
  logic fwd_hit_q;
  logic [7:0] lat_cnt_q;
  logic lat_release_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus number registers
  always_ff @(posedge clk) begin
    if (rst) begin
      up_bus_q <= BBW_BUS_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_UP_BUS)) begin
      up_bus_q <= bbw_byte_data(cfg_req, BBW_OFS_UP_BUS);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      down_bus_q <= BBW_BUS_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_DOWN_BUS)) begin
      down_bus_q <= bbw_byte_data(cfg_req, BBW_OFS_DOWN_BUS);
    end
  end

  // value stored as written; equality with the downstream number is software's job
  always_ff @(posedge clk) begin
    if (rst) begin
      high_bus_q <= BBW_BUS_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_HIGH_BUS)) begin
      high_bus_q <= bbw_byte_data(cfg_req, BBW_OFS_HIGH_BUS);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_q <= BBW_LAT_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_LAT)) begin
      lat_q <= bbw_byte_data(cfg_req, BBW_OFS_LAT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // i/o window fields, only the upper nibble is stored
  always_ff @(posedge clk) begin
    if (rst) begin
      io_window_low_field_q <= BBW_IO_FIELD_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_IO_LOW)) begin
      io_window_low_field_q <=
        cfg_req.wdata[{BBW_OFS_IO_LOW[1:0], 3'b000} + BBW_IO_FIELD_POS +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_window_high_field_q <= BBW_IO_FIELD_RST;
    end else if (bbw_byte_wr(cfg_req, BBW_OFS_IO_HIGH)) begin
      io_window_high_field_q <=
        cfg_req.wdata[{BBW_OFS_IO_HIGH[1:0], 3'b000} + BBW_IO_FIELD_POS +: 4];
    end
  end

  assign io_low_byte = {io_window_low_field_q, BBW_IO_KIND};
  assign io_high_byte = {io_window_high_field_q, BBW_IO_KIND};

  //////////////////////////////////////////////////////////////////////////////
  // downstream status flags
  // target address or attribute error
  // write target or read master data error
  // no gating by parity response enable
  assign flag_set[5] = sec_evt.addr_attr_perr | sec_evt.tgt_wr_perr | sec_evt.mst_rd_perr;
  assign flag_set[4] = sec_evt.serr;
  assign flag_set[3] = sec_evt.mabort;
  assign flag_set[2] = sec_evt.tabort_rec;
  assign flag_set[1] = sec_evt.tabort_sig;
  assign flag_set[0] = sec_evt.mst_data_perr & parity_response_enable;

  assign st_clr16[7:0] = bbw_byte_wr(cfg_req, BBW_OFS_ST_LO) ?
                         bbw_byte_data(cfg_req, BBW_OFS_ST_LO) : 8'h00;
  assign st_clr16[15:8] = bbw_byte_wr(cfg_req, BBW_OFS_ST_HI) ?
                          bbw_byte_data(cfg_req, BBW_OFS_ST_HI) : 8'h00;
  assign flag_clr = {st_clr16[BBW_ST_PAR], st_clr16[BBW_ST_SYS], st_clr16[BBW_ST_MABORT],
                     st_clr16[BBW_ST_TAB_REC], st_clr16[BBW_ST_TAB_SIG], st_clr16[BBW_ST_DPAR]};

  bbw_err_flags #(
    .N(BBW_ST_FLAGS)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flags)
  );

  always_comb begin
    status = BBW_ST_FIXED;
    status[BBW_ST_PAR] = flags[5];
    status[BBW_ST_SYS] = flags[4];
    status[BBW_ST_MABORT] = flags[3];
    status[BBW_ST_TAB_REC] = flags[2];
    status[BBW_ST_TAB_SIG] = flags[1];
    status[BBW_ST_DPAR] = flags[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration read port
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bbw_dw_rd(cfg_req, BBW_OFS_UP_BUS)) begin
      rdata_d = {lat_q, high_bus_q, down_bus_q, up_bus_q};
    end else if (bbw_dw_rd(cfg_req, BBW_OFS_IO_LOW)) begin
      rdata_d = {status, io_high_byte, io_low_byte};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= cfg_req.rd;
      hit_q <= (cfg_req.rd || cfg_req.wr) &&
               (bbw_dw_rd(cfg_req, BBW_OFS_UP_BUS) || bbw_dw_rd(cfg_req, BBW_OFS_IO_LOW) ||
                (cfg_req.wr && (cfg_req.addr[7:3] == BBW_OFS_UP_BUS[7:3])));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // type 1 configuration routing
  // own bus converts, range passes
  always_comb begin
    route_d = BBW_CFG1_IGNORE;
    if (cfg1_bus == down_bus_q) begin
      route_d = BBW_CFG1_TO_TYPE0;
    end else if ((cfg1_bus > down_bus_q) && (cfg1_bus <= high_bus_q)) begin
      route_d = BBW_CFG1_PASS;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      route_q <= BBW_CFG1_IGNORE;
      route_valid_q <= 1'b0;
    end else begin
      route_valid_q <= cfg1_valid;
      if (cfg1_valid) begin
        route_q <= route_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // i/o forwarding decision
  bbw_io_window #(
    .AW(AW)
  ) u_iowin (
    .io_window_low_field(io_window_low_field_q),
    .io_window_high_field(io_window_high_field_q),
    .base_upper(io_base_upper),
    .limit_upper(io_limit_upper),
    .addr(io_req_addr),
    .hit(win_hit)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_valid_q <= 1'b0;
      fwd_hit_q <= 1'b0;
    end else begin
      fwd_valid_q <= io_req_valid;
      fwd_hit_q <= io_req_valid && win_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master tenure latency count in bus clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_cnt_q <= 8'h00;
    end else if (sec_own_start) begin
      lat_cnt_q <= lat_q;
    end else if (sec_own_busy && (lat_cnt_q != 8'h00)) begin
      lat_cnt_q <= lat_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_release_q <= 1'b0;
    end else begin
      lat_release_q <= sec_own_busy && !sec_own_start && (lat_cnt_q == 8'h00) && !sec_gnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign cfg_hit = hit_q;
  assign cfg1_route = route_q;
  assign cfg1_route_valid = route_valid_q;
  assign io_fwd_valid = fwd_valid_q;
  assign io_fwd_hit = fwd_hit_q;
  assign lat_release = lat_release_q;
  assign upstream_bus_number = up_bus_q;
  assign downstream_bus_number = down_bus_q;
  assign highest_downstream_bus_number = high_bus_q;
  assign downstream_latency_timer = lat_q;
  assign downstream_bus_error_status = status;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [AW-1:0] chk_bottom;
  logic [AW-1:0] chk_top;
  assign chk_bottom = AW'({io_base_upper, io_window_low_field_q, 12'h000});
  assign chk_top = AW'({io_limit_upper, io_window_high_field_q, 12'hFFF});
  sequence up_bus_write_s;
    bbw_byte_wr(cfg_req, BBW_OFS_UP_BUS);
  endsequence
  sequence io_dw_read_s;
    bbw_dw_rd(cfg_req, BBW_OFS_IO_LOW) ##1 rvalid_q;
  endsequence
  up_bus_wr_a: assert property (
    @(posedge clk) disable iff (rst)
    up_bus_write_s |=> up_bus_q == $past(cfg_req.wdata[7:0]))
    else $error("upstream bus number not taken");
  down_bus_wr_a: assert property (
    @(posedge clk) disable iff (rst)
    bbw_byte_wr(cfg_req, BBW_OFS_DOWN_BUS) |=> down_bus_q == $past(cfg_req.wdata[15:8]))
    else $error("downstream bus number not taken");
  cfg1_own_bus_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg1_valid && (cfg1_bus == down_bus_q) && !bbw_byte_wr(cfg_req, BBW_OFS_DOWN_BUS)
    |=> cfg1_route_valid && (cfg1_route == BBW_CFG1_TO_TYPE0))
    else $error("own downstream bus not converted");
  cfg1_outside_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg1_valid && ((cfg1_bus < down_bus_q) || (cfg1_bus > high_bus_q))
    |=> cfg1_route == BBW_CFG1_IGNORE)
    else $error("type 1 outside range not ignored");
  lat_load_a: assert property (
    @(posedge clk) disable iff (rst)
    sec_own_start |=> lat_cnt_q == $past(lat_q))
    else $error("latency count not loaded from timer");
  io_kind_read_a: assert property (
    @(posedge clk) disable iff (rst)
    io_dw_read_s |-> (cfg_rdata[3:0] == 4'h1) && (cfg_rdata[11:8] == 4'h1))
    else $error("addressing kind nibble wrong");
  st_fixed_read_a: assert property (
    @(posedge clk) disable iff (rst)
    io_dw_read_s |-> (cfg_rdata[26:25] == 2'b01) && (cfg_rdata[22:16] == 7'h00))
    else $error("status fixed bits wrong");
  io_fwd_window_a: assert property (
    @(posedge clk) disable iff (rst)
    io_req_valid |=> io_fwd_valid &&
      (io_fwd_hit == ($past(io_req_addr) >= $past(chk_bottom) &&
                      $past(io_req_addr) <= $past(chk_top))))
    else $error("i/o forward decision wrong");
  par_flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    (sec_evt.addr_attr_perr || sec_evt.tgt_wr_perr || sec_evt.mst_rd_perr)
    |=> status[BBW_ST_PAR])
    else $error("parity flag not set");
  serr_flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    sec_evt.serr |=> status[BBW_ST_SYS])
    else $error("system error flag not set");
  flag_w1c_a: assert property (
    @(posedge clk) disable iff (rst)
    status[BBW_ST_SYS] && bbw_byte_wr(cfg_req, BBW_OFS_ST_HI) && cfg_req.wdata[30] && !sec_evt.serr
    |=> !status[BBW_ST_SYS])
    else $error("write one did not clear flag");
  flag_w0_keep_a: assert property (
    @(posedge clk) disable iff (rst)
    status[BBW_ST_PAR] && !(bbw_byte_wr(cfg_req, BBW_OFS_ST_HI) && cfg_req.wdata[31])
    |=> status[BBW_ST_PAR])
    else $error("flag lost without a clearing one");
endmodule

// ### bbw_far_model.sv
// far side model: downstream bus event pulses and bridge master tenure
`timescale 1ns/1ps
module bbw_far_model
  import bbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ev_go,
  input wire bbw_sec_evt_t ev_cmd,
  input wire logic ten_go,
  input wire logic [7:0] ten_len,
  input wire logic [7:0] gnt_len,
  output bbw_sec_evt_t sec_evt,
  output logic sec_own_start,
  output logic sec_own_busy,
  output logic sec_gnt
);
  logic [7:0] busy_q;
  logic [7:0] gnt_q;
  ////////////////////////////////////////
  // single cycle events
  always_ff @(posedge clk) begin
    sec_evt <= (ev_go && !rst) ? ev_cmd : '0;
  end
  // tenure length and grant removal
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 8'h00;
      gnt_q <= 8'h00;
      sec_own_start <= 1'b0;
    end else begin
      sec_own_start <= ten_go;
      if (ten_go) begin
        busy_q <= ten_len;
        gnt_q <= gnt_len;
      end else begin
        busy_q <= (busy_q != 8'h00) ? busy_q - 8'h01 : 8'h00;
        gnt_q <= (gnt_q != 8'h00) ? gnt_q - 8'h01 : 8'h00;
      end
    end
  end
  assign sec_own_busy = (busy_q != 8'h00);
  assign sec_gnt = (gnt_q != 8'h00);
endmodule

// ### bbw_bridge_bus_io_window_config_tb.sv
// self-checking bench for the bus number, i/o window and status bank
`timescale 1ns/1ps
module bbw_bridge_bus_io_window_config_tb
  import bbw_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bbw_cfg_req_t cfg_req = '0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid, cfg_hit, cfg1_route_valid, io_fwd_valid, io_fwd_hit, lat_release;
  logic cfg1_valid = 1'b0;
  logic [7:0] cfg1_bus = 8'h00;
  bbw_cfg1_route_t cfg1_route;
  logic io_req_valid = 1'b0;
  logic [31:0] io_req_addr = 32'h0;
  logic [15:0] io_base_upper = 16'h0;
  logic [15:0] io_limit_upper = 16'h0;
  logic parity_response_enable = 1'b0;
  bbw_sec_evt_t sec_evt;
  bbw_sec_evt_t ev_cmd = '0;
  logic ev_go = 1'b0;
  logic ten_go = 1'b0;
  logic [7:0] ten_len = 8'h00;
  logic [7:0] gnt_len = 8'h00;
  logic sec_own_start, sec_own_busy, sec_gnt;
  logic [7:0] upstream_bus_number, downstream_bus_number;
  logic [7:0] highest_downstream_bus_number, downstream_latency_timer;
  logic [15:0] downstream_bus_error_status;
  int err_total = 0;
  int checked = 0;
  integer seed = 32'h97765C7C;

  always #10 clk = ~clk;

  bbw_bridge_bus_io_window_config #(.AW(32)) i_bbw_bridge_bus_io_window_config (
    .clk, .rst, .cfg_req, .cfg_rdata, .cfg_rvalid, .cfg_hit, .cfg1_valid, .cfg1_bus,
    .cfg1_route, .cfg1_route_valid, .io_req_valid, .io_req_addr, .io_base_upper,
    .io_limit_upper, .io_fwd_valid, .io_fwd_hit, .parity_response_enable, .sec_evt,
    .sec_own_start, .sec_own_busy, .sec_gnt, .lat_release, .upstream_bus_number,
    .downstream_bus_number, .highest_downstream_bus_number, .downstream_latency_timer,
    .downstream_bus_error_status
  );

  bbw_far_model i_bbw_far_model (
    .clk, .rst, .ev_go, .ev_cmd, .ten_go, .ten_len, .gnt_len, .sec_evt, .sec_own_start,
    .sec_own_busy, .sec_gnt
  );

  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{1'b1, 1'b0, a, be, d};
    @(posedge clk);
    cfg_req <= '0;
  endtask

  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    chk(32'(cfg_rvalid), 32'h1);
    chk(32'(cfg_hit), 32'(a[7:2] == 6'h06 || a[7:2] == 6'h07));
    d = cfg_rdata;
  endtask

  task automatic cfg1_try(input logic [7:0] bus, input bbw_cfg1_route_t e);
    @(posedge clk);
    cfg1_valid <= 1'b1;
    cfg1_bus <= bus;
    @(posedge clk);
    cfg1_valid <= 1'b0;
    #1;
    chk(32'(cfg1_route_valid), 32'h1);
    chk(32'(cfg1_route), 32'(e));
  endtask

  task automatic io_try(input logic [31:0] a, input logic e);
    @(posedge clk);
    io_req_valid <= 1'b1;
    io_req_addr <= a;
    @(posedge clk);
    io_req_valid <= 1'b0;
    #1;
    chk(32'(io_fwd_valid), 32'h1);
    chk(32'(io_fwd_hit), 32'(e));
  endtask

  task automatic tenure(input logic [7:0] len, input logic [7:0] gl, output int first);
    @(posedge clk);
    ten_go <= 1'b1;
    ten_len <= len;
    gnt_len <= gl;
    @(posedge clk);
    ten_go <= 1'b0;
    first = -1;
    for (int c = 0; c < 40; c++) begin
      @(posedge clk);
      #1;
      if (first < 0 && lat_release === 1'b1) first = c;
    end
  endtask

  function automatic bbw_cfg1_route_t exp_route(logic [7:0] bus, logic [7:0] dn, logic [7:0] hi);
    if (bus == dn) return BBW_CFG1_TO_TYPE0;
    if (bus > dn && bus <= hi) return BBW_CFG1_PASS;
    return BBW_CFG1_IGNORE;
  endfunction

  function automatic logic [15:0] exp_mask(logic [2:0] idx, logic pe);
    case (idx)
      3'h7, 3'h6, 3'h5: return 16'h8000;
      3'h4: return 16'h4000;
      3'h3: return 16'h2000;
      3'h2: return 16'h1000;
      3'h1: return 16'h0800;
      default: return pe ? 16'h0100 : 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////
  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d, r, e18, lo, top, a;
    logic [7:0] b8, hi;
    logic [15:0] u, u2, m;
    int f;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cfg_rd(8'h18, r);
    chk(r, 32'h0);
    cfg_rd(8'h1C, r);
    chk(r, 32'h02800101);
    cfg_rd(8'h24, r);
    chk(r, 32'h0);
    e18 = 32'h0;
    repeat (16) begin
      d = $random(seed);
      b8 = $random(seed);
      cfg_wr(8'h18, b8[3:0], d);
      for (int i = 0; i < 4; i++) if (b8[i]) e18[8*i +: 8] = d[8*i +: 8];
      cfg_rd(8'h18, r);
      chk(r, e18);
    end
    chk({downstream_latency_timer, highest_downstream_bus_number, downstream_bus_number,
         upstream_bus_number}, e18);
    for (int j = 0; j < 6; j++) begin
      b8 = $random(seed);
      hi = b8;
      // software keeps highest equal to downstream
      cfg_wr(8'h18, 4'b0110, {8'h00, hi, b8, 8'h00});
      cfg1_try(b8, exp_route(b8, b8, hi));
      cfg1_try(b8 + 8'h01, exp_route(b8 + 8'h01, b8, hi));
      cfg1_try(b8 - 8'h01, exp_route(b8 - 8'h01, b8, hi));
      d = $random(seed);
      cfg1_try(d[7:0], exp_route(d[7:0], b8, hi));
    end
    repeat (8) begin
      d = $random(seed);
      cfg_wr(8'h1C, 4'b0011, d);
      cfg_rd(8'h1C, r);
      chk(r[15:0], {d[15:12], 4'h1, d[7:4], 4'h1});
      u = $random(seed);
      u2 = u + {15'h0, d[16]};
      @(posedge clk);
      io_base_upper <= u;
      io_limit_upper <= u2;
      lo = {u, d[7:4], 12'h000};
      top = {u2, d[15:12], 12'hFFF};
      for (int k = 0; k < 5; k++) begin
        case (k)
          0: a = lo;
          1: a = lo - 32'h1;
          2: a = top;
          3: a = top + 32'h1;
          default: a = {u, 16'(($random(seed)))};
        endcase
        io_try(a, (a >= lo) && (a <= top));
      end
    end
    for (int i = 0; i < 16; i++) begin
      m = exp_mask(i[2:0], i[3]);
      @(posedge clk);
      ev_go <= 1'b1;
      ev_cmd <= bbw_sec_evt_t'(8'h01 << i[2:0]);
      parity_response_enable <= i[3];
      @(posedge clk);
      ev_go <= 1'b0;
      @(posedge clk);
      #1;
      chk(32'(downstream_bus_error_status), 32'(16'h0280 | m));
      cfg_wr(8'h1E, 4'b1100, 32'h0);
      #1;
      chk(32'(downstream_bus_error_status), 32'(16'h0280 | m));
      cfg_wr(8'h1E, 4'b1100, {m, 16'h0});
      #1;
      chk(32'(downstream_bus_error_status), 32'h0280);
    end
    cfg_wr(8'h18, 4'b1000, 32'h04000000);
    tenure(8'd20, 8'd0, f);
    chk(32'(f >= 4 && f <= 7), 32'h1);
    tenure(8'd20, 8'd30, f);
    chk(32'(f), 32'hFFFFFFFF);
    cfg_wr(8'h18, 4'b1000, 32'h32000000);
    tenure(8'd20, 8'd0, f);
    chk(32'(f), 32'hFFFFFFFF);
    report_and_stop();
  end
endmodule
